// ==== design/tone_cadence_regs.vh ====
// register offsets, field positions and timing figures of the dual tone generator
`ifndef TONE_CADENCE_REGS_VH
`define TONE_CADENCE_REGS_VH

// direct register byte addresses
`define ADDR_IRQ_STATUS      8'h12
`define ADDR_IRQ_ENABLE      8'h15
`define ADDR_IND_DATA_LO     8'h1c
`define ADDR_IND_DATA_HI     8'h1d
`define ADDR_IND_ADDRESS     8'h1e
`define ADDR_IND_COMMIT      8'h1f
`define ADDR_TONE1_CTRL      8'h20
`define ADDR_TONE2_CTRL      8'h21
`define ADDR_TONE1_ACT_LO    8'h24
`define ADDR_TONE1_ACT_HI    8'h25
`define ADDR_TONE1_INACT_LO  8'h26
`define ADDR_TONE1_INACT_HI  8'h27
`define ADDR_TONE2_ACT_LO    8'h28
`define ADDR_TONE2_ACT_HI    8'h29
`define ADDR_TONE2_INACT_LO  8'h2a
`define ADDR_TONE2_INACT_HI  8'h2b
`define ADDR_FSK_DATA        8'h34
`define ADDR_ENHANCE_CTRL    8'h6c

// indirect register addresses
`define IND_GEN1_FREQ        8'h0d
`define IND_GEN2_PHASE       8'h12
`define IND_FSK_FIRST        8'h63
`define IND_FSK_LAST         8'h68
`define IND_COUNT            12

// control register fields
`define CTRL_SEL_RX          0
`define CTRL_SEL_TX          1
`define CTRL_OSC_EN          2
`define CTRL_INACT_TMR_EN    3
`define CTRL_ACT_TMR_EN      4
`define CTRL_ZERO_CROSS      5
`define CTRL_RELOAD          6
`define CTRL_SIGNAL_STATE    7
`define ENH_FSK_EN           6

// timing, in picoseconds
`define CORE_CLK_PERIOD_PS   4000
`define TONE_SAMPLE_PS       125000000
`define FSK_SAMPLE_PS        41666667

`endif

// ==== design/tone_cadence_gen.v ====
// dual tone generator: resonant oscillators, cadence timers, register file
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "tone_cadence_regs.vh"

module tone_osc_channel #(
	parameter TIMER_W = 16
) (
	input  wire                clk,
	input  wire                rstN,
	input  wire                tick,
	input  wire                oscEnable,
	input  wire                activeTimerEnable,
	input  wire                inactiveTimerEnable,
	input  wire                zeroCrossStop,
	input  wire                coefficientReload,
	input  wire [15:0]         freqCoeff,
	input  wire [15:0]         amplCoeff,
	input  wire [15:0]         phaseCoeff,
	input  wire [TIMER_W-1:0]  activePeriod,
	input  wire [TIMER_W-1:0]  inactivePeriod,
	output reg  [15:0]         sampleOut,
	output wire                signalOn,
	output reg                 activeExpired,
	output reg                 inactiveExpired,
	output reg                 oeSet,
	output reg                 oeClear
);
	localparam [3:0] ST_IDLE     = 4'h1;
	localparam [3:0] ST_ACTIVE   = 4'h2;
	localparam [3:0] ST_DRAIN    = 4'h4;
	localparam [3:0] ST_INACTIVE = 4'h8;

	reg  [3:0]          state_reg;
	reg  [TIMER_W-1:0]  count_reg;
	reg  [15:0]         s1_reg;
	reg  [15:0]         s2_reg;
	wire [31:0]         product;
	wire [15:0]         yNext;
	wire [TIMER_W:0]    countInc;
	wire                crossing;
	wire                timed;
	wire                actDone;
	wire                inactDone;

	// two-pole resonator: y = 2c*y1 - y2, coefficient in q15 so shift by 14
	assign product   = $signed(freqCoeff) * $signed(s1_reg); // [RL1] [RL2]
	assign yNext     = product[29:14] - s2_reg;
	assign crossing  = yNext[15] ^ s1_reg[15];
	assign timed     = activeTimerEnable | inactiveTimerEnable;
	assign countInc  = {1'b0, count_reg} + {{TIMER_W{1'b0}}, 1'b1};
	assign actDone   = countInc >= {1'b0, activePeriod}; // [RL6]
	assign inactDone = countInc >= {1'b0, inactivePeriod}; // [RL6]
	assign signalOn  = state_reg[1] | state_reg[2]; // [RL5]

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_reg       <= ST_IDLE;
			count_reg       <= {TIMER_W{1'b0}};
			s1_reg          <= 16'h0000;
			s2_reg          <= 16'h0000;
			sampleOut       <= 16'h0000;
			activeExpired   <= 1'b0;
			inactiveExpired <= 1'b0;
			oeSet           <= 1'b0;
			oeClear         <= 1'b0;
		end else begin
			activeExpired   <= 1'b0;
			inactiveExpired <= 1'b0;
			oeSet           <= 1'b0;
			oeClear         <= 1'b0;
			// suppressed outside the active burst
			sampleOut       <= signalOn ? s1_reg : 16'h0000; // [RL5]
			case (state_reg)
				ST_IDLE: begin
					// oeClear guard: the enable bit clears one edge after the pulse
					if (oscEnable && !oeClear) begin // [RL11]
						s1_reg    <= phaseCoeff;
						s2_reg    <= 16'h0000 - amplCoeff;
						count_reg <= {TIMER_W{1'b0}};
						state_reg <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (!oscEnable && !oeSet) begin // [RL11]
						state_reg <= ST_IDLE;
					end else if (tick) begin
						s1_reg <= yNext;
						s2_reg <= s1_reg;
						if (timed) begin
							if (actDone) begin
								activeExpired <= 1'b1; // [RL17]
								count_reg     <= {TIMER_W{1'b0}}; // [RL8]
								if (coefficientReload) begin
									// fsk: new coefficients, burst continues
									s1_reg <= phaseCoeff; // [RL14]
									s2_reg <= 16'h0000 - amplCoeff; // [RL14]
								end else if (zeroCrossStop && !crossing) begin
									state_reg <= ST_DRAIN; // [RL9]
								end else begin
									oeClear <= 1'b1; // [RL7] [RL24]
									if (inactiveTimerEnable)
										state_reg <= ST_INACTIVE; // [RL8]
									else
										state_reg <= ST_IDLE; // [RL10]
								end
							end else begin
								count_reg <= countInc[TIMER_W-1:0];
							end
						end
					end
				end
				ST_DRAIN: begin
					if (!oscEnable) begin
						state_reg <= ST_IDLE;
					end else if (tick) begin
						s1_reg <= yNext;
						s2_reg <= s1_reg;
						// burst ends on the sample that changes sign
						if (crossing) begin // [RL9]
							oeClear <= 1'b1; // [RL7] [RL24]
							if (inactiveTimerEnable)
								state_reg <= ST_INACTIVE;
							else
								state_reg <= ST_IDLE; // [RL10]
						end
					end
				end
				ST_INACTIVE: begin
					if (!timed) begin
						state_reg <= ST_IDLE; // [RL8]
					end else if (tick) begin
						if (inactDone) begin
							inactiveExpired <= 1'b1; // [RL17]
							oeSet           <= 1'b1; // [RL7]
							s1_reg          <= phaseCoeff;
							s2_reg          <= 16'h0000 - amplCoeff;
							count_reg       <= {TIMER_W{1'b0}}; // [RL8]
							state_reg       <= ST_ACTIVE;
						end else begin
							count_reg <= countInc[TIMER_W-1:0];
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // tone_osc_channel

// Functional notes
// RL1: two independent tone generators, each a two-pole resonant oscillator.
// RL2: each oscillator produces one sample per 8 kHz period, q15 cosine coefficient.
// RL3: software scales amplitude to 1.11 Vrms full scale, phase zero for sine.
// RL4: software writes coefficients before enabling oscillators through control registers.
// RL5: output passes only in the active period, muted in the inactive period.
// RL6: active and inactive periods are 16-bit counts of 125 us steps.
// RL7: with both timer enables set, timers drive the oscillator enable bit.
// RL8: counter runs to active expiry, restarts, runs to inactive expiry, repeats.
// RL9: zero-cross option extends each burst until the waveform crosses zero.
// RL10: oscillator and active enables without inactive enable give one burst.
// RL11: with both timer enables clear, oscillator enable bit keys the tone.
// RL12: generator 2 behaves like generator 1 with its own registers.
// RL13: software avoids generator 2 while the ringing oscillator runs.
// RL14: generator 1 reload bit reloads coefficients at each active expiry.
// RL15: fsk enable plus reload runs generator 1 at 24 kHz on mark/space sets.
// RL16: software writes only bit transitions to the fsk data register.
// RL17: every active and inactive timer expiry raises its own interrupt.
// RL18: interrupt enables in register 21, bits 0 to 3.
// RL19: pending flags readable in register 18, bits 0 to 3.
// RL20: coefficients at indirect 13-15 for generator 1, 16-18 for generator 2.
// RL21: output select routes each tone to receive or transmit path.
// RL22: software reaches indirect registers through direct registers 28 to 31.
// RL23: pending flags hold until cleared; irq only with pending and enable.
// RL24: one-shot clears the oscillator enable at active expiry.
module tone_cadence_gen #(
	parameter TIMER_W    = 16,
	parameter TONE_DIV   = `TONE_SAMPLE_PS / `CORE_CLK_PERIOD_PS,
	parameter FSK_DIV    = `FSK_SAMPLE_PS / `CORE_CLK_PERIOD_PS
) (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [7:0]  regRdData,
	output reg  [15:0] rxToneSample,
	output reg  [15:0] txToneSample,
	output wire        toneIrq
);
	reg  [1:0]          rstSync_reg;
	wire                rstN;
	reg  [15:0]         div8_reg;
	reg  [15:0]         div24_reg;
	wire                tick8;
	wire                tick24;
	reg  [15:0]         coeff_reg [0:`IND_COUNT-1];
	reg  [7:0]          indAddr_reg;
	reg  [15:0]         indData_reg;
	reg  [7:0]          tone1Ctrl_reg;
	reg  [7:0]          tone2Ctrl_reg;
	reg  [15:0]         act1_reg;
	reg  [15:0]         inact1_reg;
	reg  [15:0]         act2_reg;
	reg  [15:0]         inact2_reg;
	reg  [3:0]          irqEnable_reg;
	reg  [3:0]          irqPending_reg;
	reg  [7:0]          enhance_reg;
	reg  [7:0]          fskData_reg;
	wire                enhancedFsk;
	wire                gen1Tick;
	wire [15:0]         gen1Freq;
	wire [15:0]         gen1Ampl;
	wire [15:0]         gen1Phase;
	wire [15:0]         sample1;
	wire [15:0]         sample2;
	wire                on1;
	wire                on2;
	wire [3:0]          events;
	wire                oeSet1;
	wire                oeClr1;
	wire                oeSet2;
	wire                oeClr2;
	reg  [3:0]          indIndex;
	reg                 indHit;
	reg  [7:0]          rdNext;
	integer             i;

	// reset released through two flops
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rstSync_reg <= 2'b00;
		else
			rstSync_reg <= {rstSync_reg[0], 1'b1};
	end
	assign rstN = rstSync_reg[1];

	// sample-rate dividers; one timer step equals one 8 kHz sample, or one 24 kHz sample for generator 1 in enhanced fsk
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			div8_reg  <= 16'h0000;
			div24_reg <= 16'h0000;
		end else begin
			div8_reg  <= tick8 ? 16'h0000 : div8_reg + 16'h0001; // [RL2] [RL6]
			div24_reg <= tick24 ? 16'h0000 : div24_reg + 16'h0001; // [RL15]
		end
	end
	assign tick8  = div8_reg == TONE_DIV[15:0] - 16'h0001;
	assign tick24 = div24_reg == FSK_DIV[15:0] - 16'h0001;

	assign enhancedFsk = enhance_reg[`ENH_FSK_EN] & tone1Ctrl_reg[`CTRL_RELOAD]; // [RL15]
	assign gen1Tick    = enhancedFsk ? tick24 : tick8; // [RL15]

	// indirect map: 13..18 then 99..104 (mark/space sets) packed into one array
	always @* begin
		indHit   = 1'b0;
		indIndex = 4'h0;
		if (indAddr_reg >= `IND_GEN1_FREQ && indAddr_reg <= `IND_GEN2_PHASE) begin // [RL20]
			indHit   = 1'b1;
			indIndex = indAddr_reg[3:0] - 4'hd;
		end else if (indAddr_reg >= `IND_FSK_FIRST && indAddr_reg <= `IND_FSK_LAST) begin
			indHit   = 1'b1;
			indIndex = indAddr_reg[3:0] + 4'h3;
		end
	end

	// fsk data bit 0 picks mark (1) or space (0) set in enhanced mode
	assign gen1Freq  = enhancedFsk ? coeff_reg[fskData_reg[0] ? 6 : 7] : coeff_reg[0]; // [RL15]
	assign gen1Ampl  = enhancedFsk ? coeff_reg[fskData_reg[0] ? 8 : 9] : coeff_reg[1];
	assign gen1Phase = enhancedFsk ? coeff_reg[fskData_reg[0] ? 10 : 11] : coeff_reg[2];

	tone_osc_channel #(
		.TIMER_W(TIMER_W)
	) u_gen1 (
		.clk                 (core_clk),
		.rstN                (rstN),
		.tick                (gen1Tick),
		.oscEnable           (tone1Ctrl_reg[`CTRL_OSC_EN]),
		.activeTimerEnable   (tone1Ctrl_reg[`CTRL_ACT_TMR_EN]),
		.inactiveTimerEnable (tone1Ctrl_reg[`CTRL_INACT_TMR_EN]),
		.zeroCrossStop       (tone1Ctrl_reg[`CTRL_ZERO_CROSS]),
		.coefficientReload   (tone1Ctrl_reg[`CTRL_RELOAD]), // [RL14]
		.freqCoeff           (gen1Freq),
		.amplCoeff           (gen1Ampl),
		.phaseCoeff          (gen1Phase),
		.activePeriod        (act1_reg[TIMER_W-1:0]),
		.inactivePeriod      (inact1_reg[TIMER_W-1:0]),
		.sampleOut           (sample1),
		.signalOn            (on1),
		.activeExpired       (events[0]),
		.inactiveExpired     (events[1]),
		.oeSet               (oeSet1),
		.oeClear             (oeClr1)
	);

	// generator 2 has no reload path
	tone_osc_channel #(
		.TIMER_W(TIMER_W)
	) u_gen2 (
		.clk                 (core_clk),
		.rstN                (rstN),
		.tick                (tick8),
		.oscEnable           (tone2Ctrl_reg[`CTRL_OSC_EN]),
		.activeTimerEnable   (tone2Ctrl_reg[`CTRL_ACT_TMR_EN]),
		.inactiveTimerEnable (tone2Ctrl_reg[`CTRL_INACT_TMR_EN]),
		.zeroCrossStop       (tone2Ctrl_reg[`CTRL_ZERO_CROSS]),
		.coefficientReload   (1'b0), // [RL12] [RL14]
		.freqCoeff           (coeff_reg[3]),
		.amplCoeff           (coeff_reg[4]),
		.phaseCoeff          (coeff_reg[5]),
		.activePeriod        (act2_reg[TIMER_W-1:0]),
		.inactivePeriod      (inact2_reg[TIMER_W-1:0]),
		.sampleOut           (sample2),
		.signalOn            (on2),
		.activeExpired       (events[2]),
		.inactiveExpired     (events[3]),
		.oeSet               (oeSet2),
		.oeClear             (oeClr2)
	);

	// register writes; hardware set of a flag wins over a same-cycle clear
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			for (i = 0; i < `IND_COUNT; i = i + 1)
				coeff_reg[i] <= 16'h0000;
			indAddr_reg    <= 8'h00;
			indData_reg    <= 16'h0000;
			tone1Ctrl_reg  <= 8'h00;
			tone2Ctrl_reg  <= 8'h00;
			act1_reg       <= 16'h0000;
			inact1_reg     <= 16'h0000;
			act2_reg       <= 16'h0000;
			inact2_reg     <= 16'h0000;
			irqEnable_reg  <= 4'h0;
			irqPending_reg <= 4'h0;
			enhance_reg    <= 8'h00;
			fskData_reg    <= 8'h00;
		end else begin
			// write-one-to-clear, then new expiries set
			irqPending_reg <= (irqPending_reg & ~((regWrite &&
				regAddr == `ADDR_IRQ_STATUS) ? regWrData[3:0] : 4'h0)) | events; // [RL17] [RL23]
			if (regWrite) begin
				case (regAddr)
					`ADDR_IRQ_ENABLE:     irqEnable_reg <= regWrData[3:0]; // [RL18]
					`ADDR_IND_DATA_LO:    indData_reg[7:0] <= regWrData;
					`ADDR_IND_DATA_HI:    indData_reg[15:8] <= regWrData;
					`ADDR_IND_ADDRESS:    indAddr_reg <= regWrData;
					`ADDR_TONE1_CTRL:     tone1Ctrl_reg[6:0] <= regWrData[6:0];
					`ADDR_TONE2_CTRL:     tone2Ctrl_reg[5:0] <= regWrData[5:0];
					`ADDR_TONE1_ACT_LO:   act1_reg[7:0] <= regWrData;
					`ADDR_TONE1_ACT_HI:   act1_reg[15:8] <= regWrData;
					`ADDR_TONE1_INACT_LO: inact1_reg[7:0] <= regWrData;
					`ADDR_TONE1_INACT_HI: inact1_reg[15:8] <= regWrData;
					`ADDR_TONE2_ACT_LO:   act2_reg[7:0] <= regWrData;
					`ADDR_TONE2_ACT_HI:   act2_reg[15:8] <= regWrData;
					`ADDR_TONE2_INACT_LO: inact2_reg[7:0] <= regWrData;
					`ADDR_TONE2_INACT_HI: inact2_reg[15:8] <= regWrData;
					`ADDR_FSK_DATA:       fskData_reg <= regWrData;
					`ADDR_ENHANCE_CTRL:   enhance_reg <= regWrData;
					default: ;
				endcase
			end
			// commit writes the held data word into the indirect slot
			if (regWrite && regAddr == `ADDR_IND_COMMIT && indHit)
				coeff_reg[indIndex] <= indData_reg; // [RL20]
			// address write clears the data regs; a read of the commit register fetches the slot into them
			if (regWrite && regAddr == `ADDR_IND_ADDRESS)
				indData_reg <= 16'h0000;
			if (!(regWrite && (regAddr == `ADDR_IND_ADDRESS ||
				regAddr == `ADDR_IND_DATA_LO || regAddr == `ADDR_IND_DATA_HI)) && indHit &&
				regRead && regAddr == `ADDR_IND_COMMIT)
				indData_reg <= coeff_reg[indIndex];
			// timers own the oscillator enable in cadence modes
			if (oeClr1)
				tone1Ctrl_reg[`CTRL_OSC_EN] <= 1'b0; // [RL7] [RL24]
			if (oeSet1)
				tone1Ctrl_reg[`CTRL_OSC_EN] <= 1'b1; // [RL7]
			if (oeClr2)
				tone2Ctrl_reg[`CTRL_OSC_EN] <= 1'b0; // [RL12] [RL24]
			if (oeSet2)
				tone2Ctrl_reg[`CTRL_OSC_EN] <= 1'b1; // [RL12]
			tone1Ctrl_reg[`CTRL_SIGNAL_STATE] <= on1;
			tone2Ctrl_reg[`CTRL_SIGNAL_STATE] <= on2;
			tone2Ctrl_reg[6] <= 1'b0;
		end
	end

	assign toneIrq = |(irqPending_reg & irqEnable_reg); // [RL23]

	// read mux, answered one cycle after the strobe
	always @* begin
		case (regAddr)
			`ADDR_IRQ_STATUS:     rdNext = {4'h0, irqPending_reg}; // [RL19]
			`ADDR_IRQ_ENABLE:     rdNext = {4'h0, irqEnable_reg};
			`ADDR_IND_DATA_LO:    rdNext = indData_reg[7:0];
			`ADDR_IND_DATA_HI:    rdNext = indData_reg[15:8];
			`ADDR_IND_ADDRESS:    rdNext = indAddr_reg;
			`ADDR_TONE1_CTRL:     rdNext = tone1Ctrl_reg;
			`ADDR_TONE2_CTRL:     rdNext = tone2Ctrl_reg;
			`ADDR_TONE1_ACT_LO:   rdNext = act1_reg[7:0];
			`ADDR_TONE1_ACT_HI:   rdNext = act1_reg[15:8];
			`ADDR_TONE1_INACT_LO: rdNext = inact1_reg[7:0];
			`ADDR_TONE1_INACT_HI: rdNext = inact1_reg[15:8];
			`ADDR_TONE2_ACT_LO:   rdNext = act2_reg[7:0];
			`ADDR_TONE2_ACT_HI:   rdNext = act2_reg[15:8];
			`ADDR_TONE2_INACT_LO: rdNext = inact2_reg[7:0];
			`ADDR_TONE2_INACT_HI: rdNext = inact2_reg[15:8];
			`ADDR_FSK_DATA:       rdNext = fskData_reg;
			`ADDR_ENHANCE_CTRL:   rdNext = enhance_reg;
			default:              rdNext = 8'h00;
		endcase
	end

	// receive/transmit routing; both tones on one path add with wrap
	always @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			regRdData    <= 8'h00;
			rxToneSample <= 16'h0000;
			txToneSample <= 16'h0000;
		end else begin
			regRdData    <= regRead ? rdNext : 8'h00;
			rxToneSample <= (tone1Ctrl_reg[`CTRL_SEL_RX] ? sample1 : 16'h0000) +
				(tone2Ctrl_reg[`CTRL_SEL_RX] ? sample2 : 16'h0000); // [RL21]
			txToneSample <= (tone1Ctrl_reg[`CTRL_SEL_TX] ? sample1 : 16'h0000) +
				(tone2Ctrl_reg[`CTRL_SEL_TX] ? sample2 : 16'h0000); // [RL21]
		end
	end
endmodule // tone_cadence_gen

// ==== bench/tone_cadence_gen_properties.sv ====
// port checker for the dual tone generator, bound to its top module
`timescale 1ns/10ps
module tone_cadence_gen_properties #(
	parameter TIMER_W  = 16,
	parameter TONE_DIV = 8,
	parameter FSK_DIV  = 3
) (
	input wire        core_clk,
	input wire        resetn,
	input wire [7:0]  regAddr,
	input wire [7:0]  regWrData,
	input wire        regWrite,
	input wire        regRead,
	input wire [7:0]  regRdData,
	input wire [15:0] rxToneSample,
	input wire [15:0] txToneSample,
	input wire        toneIrq
);
	// shadows of what software wrote; hardware keying of bit 2 only makes them conservative
	reg [3:0]  enShadow;
	reg        c1Off;
	reg        c2Off;
	reg [15:0] offCnt;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			enShadow <= 4'h0;
			c1Off <= 1'b1;
			c2Off <= 1'b1;
			offCnt <= 16'h0000;
		end else begin
			if (regWrite && regAddr == 8'h15)
				enShadow <= regWrData[3:0];
			if (regWrite && regAddr == 8'h20)
				c1Off <= (regWrData[4:2] == 3'h0);
			if (regWrite && regAddr == 8'h21)
				c2Off <= (regWrData[4:2] == 3'h0);
			if (!(c1Off && c2Off))
				offCnt <= 16'h0000;
			else if (offCnt != 16'hffff)
				offCnt <= offCnt + 16'h0001;
		end
	end

	property p_rd_idle;
		@(posedge core_clk) disable iff (!resetn) !$past(regRead) |-> regRdData == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");

	property p_irq_mask;
		@(posedge core_clk) disable iff (!resetn) toneIrq |-> enShadow != 4'h0;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq with all enables off");

	property p_irq_status;
		@(posedge core_clk) disable iff (!resetn) regRead && regAddr == 8'h12
			|=> (|(regRdData[3:0] & $past(enShadow))) == $past(toneIrq);
	endproperty
	a_irq_status: assert property (p_irq_status) else $error("irq differs from status");

	property p_irq_hold;
		@(posedge core_clk) disable iff (!resetn) $fell(toneIrq)
			|-> $past(regWrite) && ($past(regAddr) == 8'h12 || $past(regAddr) == 8'h15);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a write");

	property p_en_rb;
		@(posedge core_clk) disable iff (!resetn) regWrite && regAddr == 8'h15 ##2
			regRead && regAddr == 8'h15 |=> regRdData[3:0] == $past(regWrData[3:0], 3);
	endproperty
	a_en_rb: assert property (p_en_rb) else $error("enable readback wrong");

	property p_tmr_rb;
		@(posedge core_clk) disable iff (!resetn) regWrite && regAddr >= 8'h24 && regAddr <= 8'h2b
			##2 regRead && regAddr == $past(regAddr, 2) |=> regRdData == $past(regWrData, 3);
	endproperty
	a_tmr_rb: assert property (p_tmr_rb) else $error("timer readback wrong");

	property p_gen2_noreload;
		@(posedge core_clk) disable iff (!resetn) regRead && regAddr == 8'h21 |=> !regRdData[6];
	endproperty
	a_gen2_noreload: assert property (p_gen2_noreload) else $error("gen2 reload bit set");

	property p_unmapped;
		@(posedge core_clk) disable iff (!resetn) regRead && regAddr == 8'h40 |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_quiet;
		@(posedge core_clk) disable iff (!resetn)
			offCnt > TONE_DIV + 3 |-> rxToneSample == 16'h0000 && txToneSample == 16'h0000;
	endproperty
	a_quiet: assert property (p_quiet) else $error("tone out while keyed off");
endmodule // tone_cadence_gen_properties

bind tone_cadence_gen tone_cadence_gen_properties #(
	.TIMER_W(TIMER_W), .TONE_DIV(TONE_DIV), .FSK_DIV(FSK_DIV)
) i_props (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.rxToneSample(rxToneSample), .txToneSample(txToneSample), .toneIrq(toneIrq));

// ==== bench/dual_tone_generator_cadence_test.sv ====
// self-checking bench for the dual tone generator
`timescale 1ns/10ps
module dual_tone_generator_cadence_test;
	localparam TDIV = 8;
	localparam FDIV = 3;
	reg         core_clk = 1'b0;
	reg         resetn = 1'b0;
	reg  [7:0]  regAddr = 8'h00;
	reg  [7:0]  regWrData = 8'h00;
	reg         regWrite = 1'b0;
	reg         regRead = 1'b0;
	wire [7:0]  regRdData;
	wire [15:0] rxToneSample;
	wire [15:0] txToneSample;
	wire        toneIrq;
	integer     errors = 0;
	integer     check_count = 0;
	integer     i, g, n, r;
	reg  [31:0] seed = 32'h0000f2c7;
	reg  [7:0]  d;
	reg  [15:0] v;
	reg  [15:0] m;
	reg  [15:0] cf [0:5];
	reg  [7:0]  ctl [0:3];

	tone_cadence_gen #(.TIMER_W(16), .TONE_DIV(TDIV), .FSK_DIV(FDIV)) i_dut (
		.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.rxToneSample(rxToneSample), .txToneSample(txToneSample), .toneIrq(toneIrq));

	always #2 core_clk = ~core_clk;

	function [31:0] lfsr(input [31:0] s);
		lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
	endfunction

	task chk(input [15:0] got, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("ERROR %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// one gap cycle between strobes keeps each strobe assigned once per edge
	task wr(input [7:0] a, input [7:0] x);
		begin
			@(posedge core_clk);
			regWrite <= 1'b1;
			regAddr <= a;
			regWrData <= x;
			@(posedge core_clk);
			regWrite <= 1'b0;
			#1;
		end
	endtask

	task rd(input [7:0] a, output [7:0] q);
		begin
			@(posedge core_clk);
			regRead <= 1'b1;
			regAddr <= a;
			@(posedge core_clk);
			regRead <= 1'b0;
			#1 q = regRdData;
		end
	endtask

	task ind_wr(input [7:0] ia, input [15:0] x);
		begin
			wr(8'h1e, ia);
			wr(8'h1c, x[7:0]);
			wr(8'h1d, x[15:8]);
			wr(8'h1f, 8'h00);
		end
	endtask

	task ind_chk(input [7:0] ia, input [15:0] x);
		begin
			wr(8'h1e, ia);
			rd(8'h1f, d);
			rd(8'h1c, d);
			v[7:0] = d;
			rd(8'h1d, d);
			v[15:8] = d;
			chk(v, x);
		end
	endtask

	task tick;
		begin
			@(posedge core_clk);
			#1;
		end
	endtask

	// cycles until the chosen path changes value
	task gap(input s, output [15:0] c);
		begin
			v = s ? txToneSample : rxToneSample;
			for (c = 16'h0000; c < 16'h0028 && (s ? txToneSample : rxToneSample) === v;
				c = c + 16'h0001)
				tick;
		end
	endtask

	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		errors = errors + 1;
		$display("ERROR %0t: watchdog expired", $time);
		wrap_up;
	end

	initial begin
		cf[0] = 16'h6465; cf[1] = 16'h0590; cf[2] = 16'h0000;
		cf[3] = 16'h3fc4; cf[4] = 16'h0942; cf[5] = 16'h0000;
		ctl[0] = 8'h15; ctl[1] = 8'h16; ctl[2] = 8'h55; ctl[3] = 8'h35;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 9; i = i + 1) begin
			seed = lfsr(seed);
			wr(i == 8 ? 8'h15 : 8'h24 + i[7:0], seed[7:0]);
			rd(i == 8 ? 8'h15 : 8'h24 + i[7:0], d);
			chk({8'h00, i == 8 ? {4'h0, d[3:0]} : d}, {8'h00, i == 8 ? {4'h0, seed[3:0]} : seed[7:0]});
		end
		rd(8'h40, d);
		chk({8'h00, d}, 16'h0000);
		wr(8'h21, 8'h40);
		rd(8'h21, d);
		chk({15'h0000, d[6]}, 16'h0000);
		$display("register test done");
		for (i = 0; i < 6; i = i + 1)
			ind_wr(8'h0d + i[7:0], cf[i]);
		ind_chk(8'h0e, 16'h0590);
		ind_chk(8'h10, 16'h3fc4);
		ind_chk(8'h30, 16'h0000);
		$display("indirect test done");
		// manual keying: gen1 to receive path, gen2 to transmit path
		for (g = 0; g < 2; g = g + 1) begin
			wr(8'h20 + g[7:0], g ? 8'h06 : 8'h05);
			for (n = 0; n < 20 * TDIV && (g ? txToneSample : rxToneSample) === 16'h0000; n = n + 1)
				tick;
			chk({15'h0000, (g ? txToneSample : rxToneSample) !== 16'h0000}, 16'h0001);
			chk(g ? rxToneSample : txToneSample, 16'h0000);
			gap(g[0], m);
			gap(g[0], m);
			chk(m, TDIV[15:0]);
			wr(8'h20 + g[7:0], 8'h00);
			repeat (TDIV + 4) tick;
			chk(rxToneSample | txToneSample, 16'h0000);
		end
		$display("manual test done");
		// enhanced fsk: mark/space sets, generator 1 keyed by hand at the fast rate
		for (i = 0; i < 6; i = i + 1)
			ind_wr(8'h63 + i[7:0], cf[(i % 2) * 3 + i / 2]);
		wr(8'h6c, 8'h40);
		wr(8'h34, 8'h01);
		wr(8'h20, 8'h45);
		for (n = 0; n < 20 * FDIV && rxToneSample === 16'h0000; n = n + 1)
			tick;
		gap(1'b0, m);
		gap(1'b0, m);
		chk(m, FDIV[15:0]);
		wr(8'h34, 8'h00);
		gap(1'b0, m);
		gap(1'b0, m);
		chk(m, FDIV[15:0]);
		wr(8'h20, 8'h00);
		wr(8'h6c, 8'h00);
		$display("fsk test done");
		// one-shot on each generator, generator 1 with reload, then with zero cross
		for (r = 0; r < 4; r = r + 1) begin
			g = (r == 1);
			wr(8'h24 + 4 * g[7:0], 8'h03);
			wr(8'h25 + 4 * g[7:0], 8'h00);
			wr(8'h15, 8'h01 << (2 * g));
			wr(8'h12, 8'h0f);
			wr(8'h20 + g[7:0], ctl[r]);
			d = 8'h00;
			for (n = 0; n < 10 * TDIV && !d[2 * g]; n = n + 2)
				rd(8'h12, d);
			chk({15'h0000, n >= 2 * TDIV && n <= 3 * TDIV + 6}, 16'h0001);
			chk({15'h0000, toneIrq}, 16'h0001);
			// zero cross drains past expiry; wait for the burst to end
			for (n = 0; n < 20 * TDIV && (rxToneSample | txToneSample) !== 16'h0000; n = n + 1)
				tick;
			rd(8'h20 + g[7:0], d);
			chk({15'h0000, d[2]}, {15'h0000, r == 2});
			wr(8'h20 + g[7:0], 8'h00);
			wr(8'h15, 8'h00);
			chk({15'h0000, toneIrq}, 16'h0000);
			wr(8'h15, 8'h01 << (2 * g));
			chk({15'h0000, toneIrq}, 16'h0001);
			wr(8'h12, 8'h01 << (2 * g));
			chk({15'h0000, toneIrq}, 16'h0000);
		end
		$display("one-shot test done");
		// automatic cadence: active 2 ticks, inactive 3 ticks
		wr(8'h24, 8'h02);
		wr(8'h26, 8'h03);
		wr(8'h27, 8'h00);
		wr(8'h15, 8'h03);
		wr(8'h20, 8'h1d);
		d = 8'h00;
		for (n = 0; n < 12 * TDIV && !d[1]; n = n + 2)
			rd(8'h12, d);
		chk({14'h0000, d[1:0]}, 16'h0003);
		rd(8'h20, d);
		chk({15'h0000, d[2]}, 16'h0001);
		wr(8'h20, 8'h00);
		wr(8'h12, 8'h0f);
		repeat (8 * TDIV) tick;
		rd(8'h12, d);
		chk({12'h000, d[3:0]}, 16'h0000);
		$display("cadence test done");
		wrap_up;
	end
endmodule // dual_tone_generator_cadence_test
